/* agc_pkg.sv */
// Constants, carriers and helper functions for the record gain register bank
`default_nettype none

package agc_pkg;

  // ==========================================================================
  // Register offsets and reset values
  localparam logic [7:0] ADDR_CTRL_A = 8'h1D;
  localparam logic [7:0] ADDR_CEIL = 8'h1E;
  localparam logic [7:0] ADDR_GATE = 8'h1F;
  localparam logic [7:0] ADDR_LGAIN = 8'h20;
  localparam logic [7:0] ADDR_RGAIN = 8'h21;
  localparam logic [7:0] ADDR_LDEB = 8'h22;
  localparam logic [7:0] RST_CTRL_A = 8'h00;
  localparam logic [7:0] RST_CEIL = 8'hFE;
  localparam logic [7:0] RST_GATE = 8'h00;
  localparam logic [7:0] RST_LDEB = 8'h00;
  localparam logic [7:0] RST_GAIN = 8'h00;

  // ==========================================================================
  // Field positions
  localparam int EN_BIT = 7;
  localparam int TGT_LSB = 4;
  localparam int ATK_LSB = 2;
  localparam int DCY_LSB = 0;
  localparam int CEIL_LSB = 1;
  localparam int HYS_LSB = 6;
  localparam int THR_LSB = 1;
  localparam int CLIP_BIT = 0;
  localparam int NDB_LSB = 3;
  localparam int SDB_LSB = 0;

  // ==========================================================================
  // Gain and level scales, in half-dB steps
  localparam logic [6:0] CEIL_TOP = 7'h77;
  localparam logic signed [7:0] GAIN_MIN = 8'hE8;
  localparam int TGT_HDB [8] = '{-11, -16, -20, -24, -28, -34, -40, -48};
  localparam int THR_TOP_HDB = -60;
  localparam int THR_STEP_HDB = 4;
  localparam int HYS_HDB [4] = '{2, 4, 6, 0};

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int HALF_MS_NS = 500000;
  localparam int HALF_MS_CYCLES = HALF_MS_NS / CLK_PERIOD_NS;
  localparam int HALF_MS_PER_MS = 2;
  localparam int ATK_MS [4] = '{8, 11, 16, 20};
  localparam int DCY_MS [4] = '{100, 200, 400, 500};
  localparam int NDB_HMS [8] = '{0, 1, 2, 4, 8, 16, 32, 128};
  localparam int NDB_UNIT_HMS = 128;
  localparam int NDB_LIN_BASE = 7;
  localparam int SDB_HMS [8] = '{0, 1, 2, 4, 8, 16, 32, 64};

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } agc_reg_req_t;

  typedef struct packed {
    logic [7:0] ctrl_a;
    logic [7:0] ceil;
    logic [7:0] gate;
    logic [7:0] ldeb;
    logic signed [7:0] rgain;
    logic [7:0] lgain;
    logic [7:0] rdata;
    logic [16:0] tick_cnt;
    logic [11:0] step_cnt;
    logic [11:0] db_cnt;
    logic rnoise;
    logic lstat;
    logic rsat;
    logic lsat;
  } agc_state_t;

  localparam agc_state_t ST_RST = '{ctrl_a: RST_CTRL_A, ceil: RST_CEIL,
    gate: RST_GATE, ldeb: RST_LDEB, rgain: RST_GAIN, lgain: RST_GAIN,
    rdata: 8'h00, tick_cnt: 17'h00000, step_cnt: 12'h000, db_cnt: 12'h000,
    rnoise: 1'b0, lstat: 1'b0, rsat: 1'b0, lsat: 1'b0};

  // ==========================================================================
  // Decoders
  function automatic logic signed [7:0] cap_of(input logic [6:0] c);
    return (c >= CEIL_TOP) ? signed'({1'b0, CEIL_TOP}) : signed'({1'b0, c});
  endfunction : cap_of

  function automatic logic signed [8:0] tgt_of(input logic [2:0] c);
    return 9'(TGT_HDB[c]);
  endfunction : tgt_of

  function automatic logic signed [8:0] thr_of(input logic [4:0] c);
    return 9'(THR_TOP_HDB - THR_STEP_HDB * (int'(c) - 1));
  endfunction : thr_of

  function automatic logic signed [8:0] hys_of(input logic [1:0] c);
    return 9'(HYS_HDB[c]);
  endfunction : hys_of

  function automatic logic [11:0] atk_of(input logic [1:0] c);
    return 12'(ATK_MS[c] * HALF_MS_PER_MS);
  endfunction : atk_of

  function automatic logic [11:0] dcy_of(input logic [1:0] c);
    return 12'(DCY_MS[c] * HALF_MS_PER_MS);
  endfunction : dcy_of

  function automatic logic [11:0] ndb_of(input logic [4:0] c);
    if (c <= 5'(NDB_LIN_BASE)) begin
      return 12'(NDB_HMS[c[2:0]]);
    end
    return 12'(NDB_UNIT_HMS * (int'(c) - NDB_LIN_BASE));
  endfunction : ndb_of

  function automatic logic [11:0] sdb_of(input logic [2:0] c);
    return 12'(SDB_HMS[c]);
  endfunction : sdb_of

endpackage : agc_pkg

`default_nettype wire

/* agc_regs.sv */
// Record gain control register bank with right gain loop and left debounce
//
// Contract
// - The right gain loop runs only while the enable bit 7 is set; reset 0.
// - A 3-bit target code picks -5.5 to -24 dB in eight steps, reset 000.
// - A 2-bit attack code picks 8, 11, 16 or 20 ms, reset code zero.
// - A 2-bit decay code in the low bits picks 100, 200, 400 or 500 ms.
// - Selected durations need only hold with double-rate operation off.
// - A 7-bit ceiling caps gain at code x 0.5 dB, 59.5 dB from 0x77 up.
// - A 2-bit hysteresis code gives 1, 2, 3 dB, and code 3 gives none.
// - Threshold code 0 turns detection off; else -30 dB down 2 dB a step.
// - Bit 0 of the noise gate byte turns clip stepping on; reset 0.
// - A read-only left byte reports the applied gain, reset zero.
// - A read-only right byte reports the applied gain, reset zero.
// - A 5-bit left noise debounce picks 0 to 16 ms, then 64 ms steps.
// - A 3-bit left signal debounce picks 0 to 32 ms.
// - Each channel has a flag set while applied gain equals its ceiling.
// - Each channel has a status set while the level is under threshold.
`default_nettype none

module agc_regs
  import agc_pkg::*;
#(
  parameter int HALF_MS_TICKS = HALF_MS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire agc_reg_req_t reg_req,
  output logic [7:0] rd_data,
  input wire logic signed [8:0] right_level,
  input wire logic right_clip,
  input wire logic [7:0] left_gain_in,
  input wire logic [6:0] left_ceiling_in,
  input wire logic left_quiet_raw,
  output logic right_saturated,
  output logic left_saturated,
  output logic right_below_noise,
  output logic left_below_noise
);

  // ==========================================================================
  // Reset release
  logic rst_s1;
  logic rst_q;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1 <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_q <= rst_s1;
    end
  end

  // ==========================================================================
  // State
  agc_state_t st;
  agc_state_t next_st;

  logic tick;
  logic right_en;
  logic clip_en;
  logic [4:0] thr_code;
  logic signed [8:0] thr;
  logic signed [8:0] target;
  logic signed [7:0] next_cap;
  logic [11:0] period;
  logic [11:0] need;
  logic step_up;
  logic step_dn;

  always_comb begin
    next_st = st;
    // Half-millisecond timebase; durations assume single-rate audio
    tick = (st.tick_cnt == 17'(HALF_MS_TICKS - 1));
    next_st.tick_cnt = tick ? 17'h00000 : st.tick_cnt + 17'h00001;

    // Register writes; the read-only bytes ignore writes
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        ADDR_CTRL_A: next_st.ctrl_a = reg_req.wdata;
        ADDR_CEIL: next_st.ceil = reg_req.wdata;
        ADDR_GATE: next_st.gate = reg_req.wdata;
        ADDR_LDEB: next_st.ldeb = reg_req.wdata;
        default: next_st.ldeb = st.ldeb;
      endcase
    end

    // Register reads, one cycle later; unmapped reads give zero
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        ADDR_CTRL_A: next_st.rdata = st.ctrl_a;
        ADDR_CEIL: next_st.rdata = st.ceil;
        ADDR_GATE: next_st.rdata = st.gate;
        ADDR_LGAIN: next_st.rdata = st.lgain;
        ADDR_RGAIN: next_st.rdata = st.rgain;
        ADDR_LDEB: next_st.rdata = st.ldeb;
        default: next_st.rdata = 8'h00;
      endcase
    end

    // Right noise gate with hysteresis
    thr_code = st.gate[THR_LSB +: 5];
    thr = thr_of(thr_code);
    if (thr_code == 5'h00) begin
      next_st.rnoise = 1'b0;
    end else if (st.rnoise) begin
      if (right_level >= thr + hys_of(st.gate[HYS_LSB +: 2])) begin
        next_st.rnoise = 1'b0;
      end
    end else if (right_level < thr) begin
      next_st.rnoise = 1'b1;
    end

    // Right gain loop
    right_en = st.ctrl_a[EN_BIT];
    clip_en = st.gate[CLIP_BIT];
    target = tgt_of(st.ctrl_a[TGT_LSB +: 3]);
    period = 12'h000;
    step_up = 1'b0;
    step_dn = 1'b0;
    if (right_level > target) begin
      period = atk_of(st.ctrl_a[ATK_LSB +: 2]);
    end else if (right_level < target) begin
      period = dcy_of(st.ctrl_a[DCY_LSB +: 2]);
    end
    if (!right_en) begin
      next_st.step_cnt = 12'h000;
    end else if (tick) begin
      if (clip_en && right_clip) begin
        step_dn = 1'b1;
        next_st.step_cnt = 12'h000;
      end else if (st.rnoise || period == 12'h000) begin
        next_st.step_cnt = 12'h000;
      end else if (st.step_cnt + 12'h001 >= period) begin
        step_dn = right_level > target;
        step_up = right_level < target;
        next_st.step_cnt = 12'h000;
      end else begin
        next_st.step_cnt = st.step_cnt + 12'h001;
      end
    end
    next_cap = cap_of(next_st.ceil[CEIL_LSB +: 7]);
    if (step_dn && st.rgain > GAIN_MIN) begin
      next_st.rgain = st.rgain - 8'sh01;
    end else if (step_up && st.rgain < next_cap) begin
      next_st.rgain = st.rgain + 8'sh01;
    end
    if (next_st.rgain > next_cap) begin
      next_st.rgain = next_cap;
    end
    next_st.rsat = (next_st.rgain == next_cap);

    // Left channel readback and saturation
    next_st.lgain = left_gain_in;
    next_st.lsat = ($signed(left_gain_in) == cap_of(left_ceiling_in));

    // Left detection debounce
    need = st.lstat ? sdb_of(st.ldeb[SDB_LSB +: 3])
                    : ndb_of(st.ldeb[NDB_LSB +: 5]);
    if (left_quiet_raw == st.lstat) begin
      next_st.db_cnt = 12'h000;
    end else if (need == 12'h000) begin
      next_st.lstat = left_quiet_raw;
      next_st.db_cnt = 12'h000;
    end else if (tick) begin
      if (st.db_cnt + 12'h001 >= need) begin
        next_st.lstat = left_quiet_raw;
        next_st.db_cnt = 12'h000;
      end else begin
        next_st.db_cnt = st.db_cnt + 12'h001;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_q) begin
    if (!rst_q) begin
      st <= ST_RST;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs
  assign rd_data = st.rdata;
  assign right_saturated = st.rsat;
  assign left_saturated = st.lsat;
  assign right_below_noise = st.rnoise;
  assign left_below_noise = st.lstat;

  // ==========================================================================
  // Checks
  a_ctrl_write_store: assert property (
    @(posedge ref_clk) disable iff (!rst_q)
    ce && reg_req.wr && reg_req.addr == ADDR_CTRL_A
      |=> st.ctrl_a == $past(reg_req.wdata))
    else $error("control byte write not stored");

  a_ceil_write_store: assert property (
    @(posedge ref_clk) disable iff (!rst_q)
    ce && reg_req.wr && reg_req.addr == ADDR_CEIL
      |=> st.ceil == $past(reg_req.wdata))
    else $error("ceiling byte write not stored");

  a_gate_write_store: assert property (
    @(posedge ref_clk) disable iff (!rst_q)
    ce && reg_req.wr && reg_req.addr == ADDR_GATE
      |=> st.gate == $past(reg_req.wdata))
    else $error("noise gate byte write not stored");

  a_deb_write_store: assert property (
    @(posedge ref_clk) disable iff (!rst_q)
    ce && reg_req.wr && reg_req.addr == ADDR_LDEB
      |=> st.ldeb == $past(reg_req.wdata))
    else $error("debounce byte write not stored");

  a_lgain_write_ignored: assert property (
    @(posedge ref_clk) disable iff (!rst_q)
    ce && reg_req.wr && reg_req.addr == ADDR_LGAIN
      |=> st.lgain == $past(left_gain_in))
    else $error("left gain byte took a write");

  a_gain_under_cap: assert property (
    @(posedge ref_clk) disable iff (!rst_q)
    st.rgain <= cap_of(st.ceil[CEIL_LSB +: 7]))
    else $error("right gain above ceiling");

  a_sat_flag_match: assert property (
    @(posedge ref_clk) disable iff (!rst_q)
    right_saturated == (st.rgain == cap_of(st.ceil[CEIL_LSB +: 7])))
    else $error("right saturation flag wrong");

  a_disabled_gain_hold: assert property (
    @(posedge ref_clk) disable iff (!rst_q)
    ce && !st.ctrl_a[EN_BIT] && !reg_req.wr |=> $stable(st.rgain))
    else $error("gain moved while loop disabled");

  a_step_clear_off: assert property (
    @(posedge ref_clk) disable iff (!rst_q)
    ce && !right_en |=> st.step_cnt == 12'h000)
    else $error("step counter ran while loop disabled");

  a_gain_single_step: assert property (
    @(posedge ref_clk) disable iff (!rst_q)
    !reg_req.wr ##1 1'b1 |-> st.rgain == $past(st.rgain)
      || st.rgain == $past(st.rgain) + 8'sh01
      || st.rgain == $past(st.rgain) - 8'sh01)
    else $error("gain changed by more than one step");

  a_no_step_down: assert property (
    @(posedge ref_clk) disable iff (!rst_q)
    ce && right_level < target && !(clip_en && right_clip) && !reg_req.wr
      |=> st.rgain >= $past(st.rgain))
    else $error("gain fell while level under target");

  a_no_step_up: assert property (
    @(posedge ref_clk) disable iff (!rst_q)
    ce && right_level > target
      |=> st.rgain <= $past(st.rgain))
    else $error("gain rose while level over target");

  a_clip_step_down: assert property (
    @(posedge ref_clk) disable iff (!rst_q)
    ce && tick && right_en && clip_en && right_clip
      && st.rgain > GAIN_MIN && !reg_req.wr
      |=> st.rgain == $past(st.rgain) - 8'sh01)
    else $error("clip did not step gain down");

  a_noise_hold_gain: assert property (
    @(posedge ref_clk) disable iff (!rst_q)
    ce && st.rnoise && !(clip_en && right_clip) && !reg_req.wr
      |=> $stable(st.rgain))
    else $error("gain stepped while below noise threshold");

  a_noise_detect_off: assert property (
    @(posedge ref_clk) disable iff (!rst_q)
    ce && st.gate[THR_LSB +: 5] == 5'h00 |=> !right_below_noise)
    else $error("detection active with threshold off");

  a_noise_enter: assert property (
    @(posedge ref_clk) disable iff (!rst_q)
    ce && thr_code != 5'h00 && right_level < thr
      |=> right_below_noise)
    else $error("level under threshold not flagged");

  a_hyst_hold: assert property (
    @(posedge ref_clk) disable iff (!rst_q)
    ce && st.rnoise && thr_code != 5'h00
      && right_level < thr + hys_of(st.gate[HYS_LSB +: 2])
      |=> right_below_noise)
    else $error("noise status left inside hysteresis band");

  a_right_gain_read: assert property (
    @(posedge ref_clk) disable iff (!rst_q)
    ce && reg_req.rd && reg_req.addr == ADDR_RGAIN
      |=> rd_data == $past(st.rgain))
    else $error("right gain readback wrong");

  a_left_gain_read: assert property (
    @(posedge ref_clk) disable iff (!rst_q)
    ce && reg_req.rd && reg_req.addr == ADDR_LGAIN
      |=> rd_data == $past(st.lgain))
    else $error("left gain readback wrong");

  a_zero_debounce: assert property (
    @(posedge ref_clk) disable iff (!rst_q)
    ce && left_quiet_raw && !st.lstat && st.ldeb[NDB_LSB +: 5] == 5'h00
      |=> left_below_noise)
    else $error("zero noise debounce did not act at once");

  a_signal_zero_debounce: assert property (
    @(posedge ref_clk) disable iff (!rst_q)
    ce && !left_quiet_raw && st.lstat && st.ldeb[SDB_LSB +: 3] == 3'h0
      |=> !left_below_noise)
    else $error("zero signal debounce did not act at once");

endmodule : agc_regs

`default_nettype wire

/* testbench.sv */
// Self-checking testbench for the record gain register bank
`default_nettype none

`define CHK(got, exp) \
  begin \
    checks++; \
    if ((got) !== (exp)) begin \
      num_errors++; \
      $display("BAD %0t got %h exp %h", $time, got, exp); \
    end \
  end

module testbench import agc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Signals
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  agc_reg_req_t reg_req = '0;
  logic [7:0] rd_data;
  logic signed [8:0] right_level = 9'h000;
  logic right_clip = 1'b0;
  logic [7:0] left_gain_in = 8'h00;
  logic [6:0] left_ceiling_in = 7'h00;
  logic left_quiet_raw = 1'b0;
  logic right_saturated;
  logic left_saturated;
  logic right_below_noise;
  logic left_below_noise;
  logic [7:0] flags;
  int num_errors = 0;
  int checks = 0;
  logic [7:0] exp_q [$];
  logic rd_pend = 1'b0;
  logic fl_pend = 1'b0;
  logic probe_on = 1'b0;
  logic [7:0] rstv [7] = '{8'h00, 8'hFE, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] adr [4] = '{8'h1D, 8'h1E, 8'h1F, 8'h22};
  logic [7:0] msk [4] = '{8'h7F, 8'hFE, 8'hFF, 8'hFF};

  assign flags = {4'h0, right_saturated, left_saturated, right_below_noise,
    left_below_noise};

  always #2 ref_clk = ~ref_clk;

  // ==========================================================================
  // Design
  agc_regs #(.HALF_MS_TICKS(2)) u_agc_regs (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .ce(ce),
    .reg_req(reg_req),
    .rd_data(rd_data),
    .right_level(right_level),
    .right_clip(right_clip),
    .left_gain_in(left_gain_in),
    .left_ceiling_in(left_ceiling_in),
    .left_quiet_raw(left_quiet_raw),
    .right_saturated(right_saturated),
    .left_saturated(left_saturated),
    .right_below_noise(right_below_noise),
    .left_below_noise(left_below_noise)
  );

  // ==========================================================================
  // Output watcher
  always @(posedge ref_clk) begin : watch
    logic [7:0] e;
    if (rd_pend || fl_pend) begin
      e = exp_q.pop_front();
      if (rd_pend) begin
        `CHK(rd_data, e)
      end else begin
        `CHK(flags, e)
      end
    end
    rd_pend <= reg_req.rd & ce;
    fl_pend <= probe_on;
  end

  // ==========================================================================
  // Tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_req.wr <= 1'b1;
    reg_req.addr <= a;
    reg_req.wdata <= d;
    @(posedge ref_clk);
    reg_req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge ref_clk);
    reg_req.rd <= 1'b1;
    reg_req.addr <= a;
    @(posedge ref_clk);
    reg_req.rd <= 1'b0;
  endtask : rd

  task automatic probe(input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge ref_clk);
    probe_on <= 1'b1;
    @(posedge ref_clk);
    probe_on <= 1'b0;
  endtask : probe

  task automatic wrap_up();
    if (exp_q.size() != 0) begin
      num_errors++;
      $display("BAD %0t %0d results never seen", $time, exp_q.size());
    end
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  // ==========================================================================
  // Watchdog
  initial begin
    #40000;
    num_errors++;
    $display("BAD %0t watchdog expired", $time);
    wrap_up();
  end

  // ==========================================================================
  // Tests
  initial begin
    logic [7:0] v;
    void'($urandom(19));
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    // Reset values, last offset unmapped
    for (int i = 0; i < 7; i++) begin
      rd(8'h1D + 8'(i), rstv[i]);
    end
    $display("test reset values done");
    // Random write and readback of the control bytes
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom()) & msk[i];
      wr(adr[i], v);
      rd(adr[i], v);
    end
    wr(8'h21, 8'hAA);
    rd(8'h21, 8'h00);
    @(posedge ref_clk);
    ce <= 1'b0;
    wr(8'h22, 8'h5A);
    ce <= 1'b1;
    rd(8'h22, v);
    $display("test readback done");
    // Saturation and detection flags
    wr(8'h1E, 8'h00);
    wr(8'h1F, 8'h02);
    wr(8'h22, 8'h00);
    left_gain_in <= 8'h77;
    left_ceiling_in <= 7'h7F;
    left_quiet_raw <= 1'b1;
    right_level <= 9'h19C;
    repeat (4) @(posedge ref_clk);
    probe(8'h0F);
    left_gain_in <= 8'h76;
    left_quiet_raw <= 1'b0;
    right_level <= 9'h000;
    repeat (4) @(posedge ref_clk);
    probe(8'h08);
    $display("test flags done");
    // Gain loop: attack step, hold while off, decay step
    wr(8'h1F, 8'h00);
    wr(8'h1E, 8'hFE);
    wr(8'h1D, 8'h80);
    repeat (40) @(posedge ref_clk);
    rd(8'h21, 8'hFF);
    wr(8'h1D, 8'h00);
    repeat (100) @(posedge ref_clk);
    rd(8'h21, 8'hFF);
    right_level <= 9'h19C;
    wr(8'h1D, 8'h80);
    repeat (420) @(posedge ref_clk);
    rd(8'h21, 8'h00);
    $display("test gain loop done");
    // Clip stepping down to the gain floor
    wr(8'h1F, 8'h01);
    right_clip <= 1'b1;
    repeat (60) @(posedge ref_clk);
    right_clip <= 1'b0;
    rd(8'h21, 8'hE8);
    $display("test clip stepping done");
    // Reset again in mid-run
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(8'h1D, 8'h00);
    rd(8'h1E, 8'hFE);
    rd(8'h21, 8'h00);
    $display("test second reset done");
    repeat (2) @(posedge ref_clk);
    wrap_up();
  end

endmodule : testbench

`default_nettype wire
